// ===== common/pls_pkg.sv
// package: constants, register map and carrier types of the pid loop sample scheduler
package pls_pkg;

  // ---------------------------------------------------------------------------
  // sizes
  // ---------------------------------------------------------------------------
  localparam int          NUM_LOOPS  = 8;
  localparam int          LOOP_W     = 3;
  localparam int          TICK_W     = 14;   // up to 9999 ticks of 10 ms

  // ---------------------------------------------------------------------------
  // timing
  // ---------------------------------------------------------------------------
  localparam int          CLK_MHZ        = 200;
  localparam int          TICK_US        = 10000;                 // 10 ms time base
  localparam int          TICK_CYCLES    = TICK_US * CLK_MHZ;     // 2,000,000 cycles
  localparam logic [13:0] FAST_LIMIT     = 14'd200;               // 2 s in 10 ms ticks
  localparam logic [13:0] MIN_PERIOD     = 14'd5;                 // 00.05 s
  localparam int          CALC_NS        = 250;                   // one pid calculation
  localparam int          CALC_CYCLES    = (CALC_NS * CLK_MHZ + 999) / 1000;

  // ---------------------------------------------------------------------------
  // register map: per loop period words at index 0x07 of a 0x10 word slot
  // ---------------------------------------------------------------------------
  localparam logic [11:0] PERIOD_IDX     = 12'h007;
  localparam logic [11:0] LOOP_STRIDE    = 12'h040;                // bytes per loop slot
  localparam logic [11:0] PERIOD_BASE    = 12'h01c;                // 4 * 0x07
  localparam logic [11:0] CTRL_ADDR      = 12'h800;
  localparam logic [11:0] STATUS_ADDR    = 12'h804;
  localparam logic [11:0] IRQ_STAT_ADDR  = 12'h808;
  localparam logic [11:0] IRQ_MASK_ADDR  = 12'h80c;
  localparam logic [11:0] RS_ADDR_ADDR   = 12'h810;
  localparam logic [11:0] RS_ERR_ADDR    = 12'h814;
  localparam logic [11:0] CALC_CNT_ADDR  = 12'h818;
  localparam logic [11:0] ROC_ADDR       = 12'h81c;

  // ---------------------------------------------------------------------------
  // fields and reset values
  // ---------------------------------------------------------------------------
  localparam int          CTRL_RUN_BIT   = 0;
  localparam int          CTRL_LAST_LSB  = 4;
  localparam int          ERR_LOW_BIT    = 0;
  localparam int          ERR_HIGH_BIT   = 1;
  localparam int          ERR_SYS_BIT    = 4;
  localparam int          IRQ_CALC_BIT   = 0;
  localparam int          IRQ_RSERR_BIT  = 1;
  localparam int          IRQ_ROC_BIT    = 2;
  localparam logic [15:0] PERIOD_RST     = 16'h0000;
  localparam logic [15:0] USER_LOW       = 16'h0400;
  localparam logic [15:0] USER_HIGH      = 16'h3fff;
  localparam logic [15:0] SYS_LOW        = 16'h7000;
  localparam logic [15:0] SYS_HIGH       = 16'h77ff;

  // ---------------------------------------------------------------------------
  // types
  // ---------------------------------------------------------------------------
  typedef enum logic [1:0] {PLS_IDLE, PLS_FAST, PLS_SLOW, PLS_CALC} pls_state_e;

  typedef struct packed {
    logic             valid;
    logic [LOOP_W-1:0] loop;
  } pls_calc_s;

  typedef struct packed {
    logic        sel;
    logic        write;
    logic [11:0] addr;
  } pls_req_s;

endpackage : pls_pkg

// ===== rtl/pls_period_mem.sv
// file: per loop sample period storage with registered read data
`timescale 1ns/100ps
`default_nettype none
module pls_period_mem (
  input  wire logic                        hclk,
  input  wire logic                        hresetn,
  input  wire logic                        wr_en,
  input  wire logic [pls_pkg::LOOP_W-1:0]  wr_loop,
  input  wire logic [15:0]                 wr_data,
  input  wire logic [pls_pkg::LOOP_W-1:0]  rd_loop,
  output logic      [15:0]                 rd_data
);
  import pls_pkg::*;

  logic [15:0] words [NUM_LOOPS];

  // storage, cleared so an unset loop stays idle
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      for (int i = 0; i < NUM_LOOPS; i++) begin
        words[i] <= PERIOD_RST;
      end
    end else if (wr_en) begin
      words[wr_loop] <= wr_data;
    end
  end

  // read port is registered
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      rd_data <= PERIOD_RST;
    end else begin
      rd_data <= words[rd_loop];
    end
  end
endmodule : pls_period_mem
`default_nettype wire

// ===== rtl/pls_scheduler.sv
// file: pid loop sample scheduler with ahb-lite register slave
//
// Register access over AHB-Lite was left to the implementer.
`timescale 1ns/100ps
`default_nettype none
module pls_scheduler #(
  parameter int TICK_CYCLES_P = pls_pkg::TICK_CYCLES
) (
  input  wire logic                        hclk,
  input  wire logic                        hresetn,
  input  wire logic                        hsel,
  input  wire logic [31:0]                 haddr,
  input  wire logic [1:0]                  htrans,
  input  wire logic                        hwrite,
  input  wire logic [2:0]                  hsize,
  input  wire logic [31:0]                 hwdata,
  input  wire logic                        hready,
  output logic      [31:0]                 hrdata,
  output logic                             hreadyout,
  output logic                             hresp,
  input  wire logic                        ladder_done,
  input  wire logic [15:0]                 pv_delta,
  output pls_pkg::pls_calc_s               calc,
  output logic                             irq
);
  import pls_pkg::*;

  // ---------------------------------------------------------------------------
  // helpers
  // ---------------------------------------------------------------------------
  // packed bcd dd.dd seconds to 10 ms ticks
  function automatic logic [TICK_W-1:0] bcd_ticks(input logic [15:0] b);
    logic [TICK_W-1:0] r;
    r = TICK_W'(b[15:12]) * TICK_W'(1000) + TICK_W'(b[11:8]) * TICK_W'(100)
      + TICK_W'(b[7:4]) * TICK_W'(10) + TICK_W'(b[3:0]);
    return r;
  endfunction : bcd_ticks

  function automatic logic is_fast(input logic [TICK_W-1:0] t);
    return (t <= FAST_LIMIT);
  endfunction : is_fast

  // wrap a cursor at the highest configured loop
  function automatic logic [LOOP_W-1:0] next_loop(input logic [LOOP_W-1:0] c,
                                                  input logic [LOOP_W-1:0] last);
    return (c >= last) ? '0 : c + 1'b1;
  endfunction : next_loop

  // ---------------------------------------------------------------------------
  // registers
  // ---------------------------------------------------------------------------
  pls_req_s           req;
  logic               run;
  logic [LOOP_W-1:0]  last_loop;
  logic [15:0]        rs_addr;
  logic [15:0]        rs_err;
  logic [2:0]         irq_stat;
  logic [2:0]         irq_mask;
  logic [15:0]        roc_limit;
  logic [15:0]        calc_cnt;
  logic [NUM_LOOPS-1:0] due;
  logic [NUM_LOOPS-1:0] fast;
  logic [TICK_W-1:0]  ticks [NUM_LOOPS];
  logic [TICK_W-1:0]  period [NUM_LOOPS];
  logic [31:0]        tick_cnt;
  logic               tick;
  logic               scan_go;
  pls_state_e         state;
  logic [LOOP_W-1:0]  fast_cur;
  logic [LOOP_W-1:0]  slow_cur;
  logic [7:0]         calc_wait;
  logic [LOOP_W-1:0]  calc_loop;
  logic               calc_done;
  logic               roc_ev;
  logic               period_hit;
  logic [LOOP_W-1:0]  period_loop;
  logic [15:0]        mem_rd;
  logic [LOOP_W-1:0]  rd_loop;
  logic [2:0]         next_rs_err_ev;

  // ---------------------------------------------------------------------------
  // ahb-lite slave: writes with no wait, reads with one wait state, always okay
  // ---------------------------------------------------------------------------
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      req       <= '0;
      hreadyout <= 1'b1;
      hresp     <= 1'b0;
    end else begin
      req.sel   <= hsel && hready && htrans[1];
      req.write <= hwrite;
      req.addr  <= haddr[11:0];
      // the period memory answers a cycle late, so a read stretches its data phase
      hreadyout <= !(hsel && hready && htrans[1] && !hwrite);
    end
  end

  // period word writes land in loop slots; other offsets read back zero
  assign period_hit  = req.addr < (LOOP_STRIDE * NUM_LOOPS)
                       && (req.addr & (LOOP_STRIDE - 12'h001)) == PERIOD_BASE;
  assign period_loop = req.addr[8:6];
  assign rd_loop     = haddr[8:6];

  pls_period_mem u_mem (
    .hclk    (hclk),
    .hresetn (hresetn),
    .wr_en   (req.sel && req.write && period_hit),
    .wr_loop (period_loop),
    .wr_data (hwdata[15:0]),
    .rd_loop (rd_loop),
    .rd_data (mem_rd)
  );

  // control, masks, table pointer and alarm limit
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      run       <= 1'b0;
      last_loop <= LOOP_W'(NUM_LOOPS - 1);
      irq_mask  <= '0;
      rs_addr   <= USER_LOW;
      roc_limit <= '0;
    end else if (req.sel && req.write) begin
      case (req.addr)
        CTRL_ADDR: begin
          run       <= hwdata[CTRL_RUN_BIT];
          last_loop <= hwdata[CTRL_LAST_LSB +: LOOP_W];
        end
        IRQ_MASK_ADDR: irq_mask  <= hwdata[2:0];
        RS_ADDR_ADDR:  rs_addr   <= hwdata[15:0];
        ROC_ADDR:      roc_limit <= hwdata[15:0];
        default: ;
      endcase
    end
  end

  // read mux; period words come from the memory's registered port
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      hrdata <= '0;
    end else begin
      hrdata <= '0;
      if (req.sel && !req.write) begin
        case (req.addr)
          CTRL_ADDR:     hrdata <= {25'h0, last_loop, 3'h0, run};
          STATUS_ADDR:   hrdata <= {22'h0, fast_cur, slow_cur, state, 2'h0};
          IRQ_STAT_ADDR: hrdata <= {29'h0, irq_stat};
          IRQ_MASK_ADDR: hrdata <= {29'h0, irq_mask};
          RS_ADDR_ADDR:  hrdata <= {16'h0, rs_addr};
          RS_ERR_ADDR:   hrdata <= {16'h0, rs_err};
          CALC_CNT_ADDR: hrdata <= {16'h0, calc_cnt};
          ROC_ADDR:      hrdata <= {16'h0, roc_limit};
          default:       hrdata <= period_hit ? {16'h0, mem_rd} : 32'h0;
        endcase
      end
    end
  end

  // ---------------------------------------------------------------------------
  // ramp/soak table address check
  // ---------------------------------------------------------------------------
  always_comb begin
    next_rs_err_ev = '0;
    next_rs_err_ev[0] = rs_addr < USER_LOW;
    next_rs_err_ev[1] = rs_addr > USER_HIGH && rs_addr < SYS_LOW;
    next_rs_err_ev[2] = rs_addr >= SYS_LOW && rs_addr <= SYS_HIGH;
  end

  // read-only flags, reserved bits zero
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      rs_err <= '0;
    end else begin
      rs_err                <= '0;
      rs_err[ERR_LOW_BIT]   <= next_rs_err_ev[0];
      rs_err[ERR_HIGH_BIT]  <= next_rs_err_ev[1];
      rs_err[ERR_SYS_BIT]   <= next_rs_err_ev[2];
    end
  end

  // ---------------------------------------------------------------------------
  // 10 ms time base and per loop accumulators
  // ---------------------------------------------------------------------------
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      tick_cnt <= '0;
      tick     <= 1'b0;
    end else begin
      tick     <= (tick_cnt == 32'(TICK_CYCLES_P - 1));
      tick_cnt <= (tick_cnt == 32'(TICK_CYCLES_P - 1)) ? '0 : tick_cnt + 32'h1;
    end
  end

  // shadow the decoded periods, one loop slot per generate lane
  genvar g;
  generate
    for (g = 0; g < NUM_LOOPS; g++) begin : g_loop
      always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
          period[g] <= '0;
        end else if (req.sel && req.write && period_hit && period_loop == LOOP_W'(g)) begin
          period[g] <= bcd_ticks(hwdata[15:0]);
        end
      end

      assign fast[g] = is_fast(period[g]);

      // accumulator runs regardless of ladder activity; due flag sticks until served
      always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
          ticks[g] <= '0;
          due[g]   <= 1'b0;
        end else begin
          if (period[g] < MIN_PERIOD || LOOP_W'(g) > last_loop) begin
            ticks[g] <= '0;
            due[g]   <= 1'b0;
          end else begin
            if (tick) begin
              if (ticks[g] + TICK_W'(1) >= period[g]) begin
                ticks[g] <= '0;
                due[g]   <= 1'b1;
              end else begin
                ticks[g] <= ticks[g] + TICK_W'(1);
              end
            end
            if (calc_done && calc_loop == LOOP_W'(g) && !(tick && ticks[g] + TICK_W'(1) >= period[g])) begin
              due[g] <= 1'b0;
            end
          end
        end
      end
    end
  endgenerate

  // ---------------------------------------------------------------------------
  // scan sequencer
  // ---------------------------------------------------------------------------
  // ladder end starts the pid task; with ladder stopped each tick starts one
  assign scan_go = run ? ladder_done : tick;

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      state     <= PLS_IDLE;
      fast_cur  <= '0;
      slow_cur  <= '0;
      calc_loop <= '0;
      calc_wait <= '0;
      calc_done <= 1'b0;
    end else begin
      calc_done <= 1'b0;
      case (state)
        PLS_IDLE: begin
          if (scan_go) begin
            state    <= PLS_FAST;
            fast_cur <= '0;
          end
        end
        PLS_FAST: begin
          // walk loops 0 to last_loop once; any due fast loop is calculated now
          if (fast[fast_cur] && due[fast_cur]) begin
            calc_loop <= fast_cur;
            calc_wait <= 8'(CALC_CYCLES);
            state     <= PLS_CALC;
          end else if (fast_cur >= last_loop) begin
            state <= PLS_SLOW;
          end else begin
            fast_cur <= fast_cur + 1'b1;
          end
        end
        PLS_SLOW: begin
          // one step of the slow cursor per scan, onto a due slow loop to calculate it or past a fast loop; a slow loop not yet due holds it
          if (!fast[next_loop(slow_cur, last_loop)] && due[next_loop(slow_cur, last_loop)]) begin
            slow_cur  <= next_loop(slow_cur, last_loop);
            calc_loop <= next_loop(slow_cur, last_loop);
            calc_wait <= 8'(CALC_CYCLES);
            state     <= PLS_CALC;
            fast_cur  <= last_loop;
          end else if (fast[next_loop(slow_cur, last_loop)]) begin
            slow_cur <= next_loop(slow_cur, last_loop);
            state    <= PLS_IDLE;
          end else begin
            state <= PLS_IDLE;
          end
        end
        PLS_CALC: begin
          if (calc_wait <= 8'h1) begin
            calc_done <= 1'b1;
            if (fast[calc_loop] && fast_cur < last_loop) begin
              fast_cur <= fast_cur + 1'b1;
              state    <= PLS_FAST;
            end else if (fast[calc_loop] && fast_cur >= last_loop) begin
              state <= PLS_SLOW;
            end else begin
              state <= PLS_IDLE;
            end
          end else begin
            calc_wait <= calc_wait - 8'h1;
          end
        end
        default: state <= PLS_IDLE;
      endcase
    end
  end

  // ---------------------------------------------------------------------------
  // calculation strobe, counter and rate alarm
  // ---------------------------------------------------------------------------
  // each finished calculation issues a fresh output strobe for its loop
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      calc     <= '0;
      calc_cnt <= '0;
      roc_ev   <= 1'b0;
    end else begin
      calc.valid <= calc_done;
      calc.loop  <= calc_loop;
      if (calc_done) begin
        calc_cnt <= calc_cnt + 16'h1;
      end
      // delta is change since last sample, so limit is per sample period
      roc_ev <= calc_done && roc_limit != 16'h0 && pv_delta > roc_limit;
    end
  end

  // ---------------------------------------------------------------------------
  // interrupts: sticky status, write one to clear, set wins
  // ---------------------------------------------------------------------------
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      irq_stat <= '0;
    end else begin
      if (req.sel && req.write && req.addr == IRQ_STAT_ADDR) begin
        irq_stat <= irq_stat & ~hwdata[2:0];
      end
      if (calc_done) irq_stat[IRQ_CALC_BIT] <= 1'b1;
      if (|next_rs_err_ev) irq_stat[IRQ_RSERR_BIT] <= 1'b1;
      if (roc_ev) irq_stat[IRQ_ROC_BIT] <= 1'b1;
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      irq <= 1'b0;
    end else begin
      irq <= |(irq_stat & irq_mask);
    end
  end
endmodule : pls_scheduler
`default_nettype wire

// ===== verif/pls_scheduler_chk.sv
// checker: bus answer and calculation pulse properties of the loop scheduler
`timescale 1ns/100ps
`default_nettype none
module pls_scheduler_chk import pls_pkg::*; #(
  parameter int TICK_CYCLES_P = 20
) (
  input wire logic               hclk,
  input wire logic               hresetn,
  input wire logic               hsel,
  input wire logic [1:0]         htrans,
  input wire logic               hwrite,
  input wire logic               hready,
  input wire logic [31:0]        hrdata,
  input wire logic               hreadyout,
  input wire logic               hresp,
  input wire pls_pkg::pls_calc_s calc,
  input wire logic               irq
);
  logic [31:0] since_rst;
  logic        take;
  // a bus request is taken on a nonseq or seq transfer while selected and ready
  assign take = hsel && hready && htrans[1];
  default clocking cb @(posedge hclk); endclocking
  default disable iff (!hresetn);
  // cycles since reset, saturating so a long run never wraps to zero
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      since_rst <= '0;
    end else if (since_rst != '1) begin
      since_rst <= since_rst + 32'h1;
    end
  end
  a_ready_high: assert property (!hreadyout |-> $past(take && !hwrite))
    else $error("hreadyout low without a read");
  a_ready_wait: assert property (take && !hwrite |=> !hreadyout ##1 hreadyout)
    else $error("read wait state not exactly one cycle");
  a_resp_okay: assert property (!hresp)
    else $error("error response seen");
  a_calc_pulse: assert property (calc.valid |=> !calc.valid)
    else $error("calc valid longer than one cycle");
  a_calc_gap: assert property (calc.valid |=> !calc.valid [*8])
    else $error("two calculations too close");
  a_rdata_cause: assert property (hrdata != 32'h0 |-> $past(take && !hwrite, 2))
    else $error("read data without a read");
  a_write_quiet: assert property (take && hwrite |-> ##2 hrdata == 32'h0)
    else $error("read data after a write");
  a_first_calc: assert property (calc.valid |-> since_rst >= 4 * TICK_CYCLES_P)
    else $error("calculation before shortest period");
  a_quiet_start: assert property (!$past(hresetn) |-> !calc.valid && !irq)
    else $error("activity at reset release");
endmodule : pls_scheduler_chk
bind pls_scheduler pls_scheduler_chk #(.TICK_CYCLES_P(TICK_CYCLES_P)) chk_u (
  .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .htrans(htrans), .hwrite(hwrite),
  .hready(hready), .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp),
  .calc(calc), .irq(irq));
`default_nettype wire

// ===== verif/tb_pls_scheduler.sv
// testbench: register map, loop scheduling, interrupts and reset of the scheduler
`timescale 1ns/100ps
`default_nettype none
`define CHK(nm, ex, got) begin cmp_count++; if ((got) !== (ex)) begin err_count++; \
  $display("wrong value %s expected %h seen %h", nm, ex, got); end end
module tb_pls_scheduler;
  import pls_pkg::*;
  localparam int TICK  = 200;    // short tick keeps slow loops within the run
  localparam int LIMIT = 60000;
  typedef struct {logic [11:0] wa; logic [15:0] wd; logic [11:0] ra; logic [15:0] ex;} pls_row_s;
  logic        hclk = 0, hresetn = 0, hsel = 0, hwrite = 0, ladder_done = 0;
  logic [31:0] haddr = 0, hwdata = 0, hrdata, rd;
  logic [1:0]  htrans = 0;
  logic [2:0]  hsize = 3'h2;
  logic [15:0] pv_delta = 0;
  logic        hready, hreadyout, hresp, irq;
  pls_calc_s   calc;
  int          err_count = 0, cmp_count = 0, cyc = 0, s0;
  int          cnt[NUM_LOOPS], tcal[NUM_LOOPS];
  pls_row_s    rows[10] = '{
    '{RS_ADDR_ADDR, 16'h03ff, RS_ERR_ADDR, 16'h0001}, '{RS_ADDR_ADDR, 16'h0400, RS_ERR_ADDR, 16'h0000},
    '{RS_ADDR_ADDR, 16'h3fff, RS_ERR_ADDR, 16'h0000}, '{RS_ADDR_ADDR, 16'h4000, RS_ERR_ADDR, 16'h0002},
    '{RS_ADDR_ADDR, 16'h6fff, RS_ERR_ADDR, 16'h0002}, '{RS_ADDR_ADDR, 16'h7000, RS_ERR_ADDR, 16'h0010},
    '{RS_ADDR_ADDR, 16'h77ff, RS_ERR_ADDR, 16'h0010}, '{RS_ERR_ADDR, 16'hffff, RS_ERR_ADDR, 16'h0010},
    '{12'hfe0, 16'h1234, 12'hfe0, 16'h0000}, '{IRQ_MASK_ADDR, 16'h0002, IRQ_MASK_ADDR, 16'h0002}};
  assign hready = hreadyout;  // single slave: its ready is the bus ready
  always #2.5 hclk = ~hclk;
  pls_scheduler #(.TICK_CYCLES_P(TICK)) dut_u (
    .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hready), .hrdata(hrdata),
    .hreadyout(hreadyout), .hresp(hresp), .ladder_done(ladder_done), .pv_delta(pv_delta),
    .calc(calc), .irq(irq));
  // ---------------------------------------------------------------------------
  // bus cycles and bookkeeping
  // ---------------------------------------------------------------------------
  // read data stands at the edge that ends the data phase, after one wait state
  task automatic bus(input logic wr, input logic [11:0] a, input logic [15:0] d);
    hsel <= 1'b1; htrans <= 2'h2; haddr <= {20'h0, a}; hwrite <= wr;
    @(posedge hclk);
    while (hreadyout !== 1'b1) @(posedge hclk);
    hsel <= 1'b0; htrans <= 2'h0; hwdata <= wr ? {16'h0, d} : 32'h0;
    @(posedge hclk);
    while (hreadyout !== 1'b1) @(posedge hclk);
    if (!wr) begin
      rd = hrdata;
    end
  endtask : bus
  function automatic int total();
    total = 0;
    foreach (cnt[i]) total += cnt[i];
  endfunction : total
  task automatic tally_and_finish();
    $display("comparisons %0d mismatches %0d", cmp_count, err_count);
    if (err_count == 0 && cmp_count > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask : tally_and_finish
  // cycle count for the hang guard, and per loop count and time of finished calculations
  always @(posedge hclk) begin
    cyc++;
    if (calc.valid === 1'b1) begin
      cnt[calc.loop]++;
      tcal[calc.loop] = cyc;
    end
    if (cyc == LIMIT) begin
      err_count++;
      tally_and_finish();
    end
  end
  // ---------------------------------------------------------------------------
  // tests
  // ---------------------------------------------------------------------------
  initial begin
    cnt = '{default: 0};
    tcal = '{default: 0};
    repeat (3) @(posedge hclk);
    hresetn <= 1'b1;
    foreach (rows[i]) begin
      bus(1'b1, rows[i].wa, rows[i].wd);
      bus(1'b0, rows[i].ra, 16'h0);
      `CHK("register row", rows[i].ex, rd[15:0])
    end
    repeat (3) @(posedge hclk);
    `CHK("irq on address error", 1'b1, irq)
    bus(1'b1, RS_ADDR_ADDR, 16'h0400);
    bus(1'b1, IRQ_STAT_ADDR, 16'h0007);
    repeat (3) @(posedge hclk);
    `CHK("irq cleared", 1'b0, irq)
    $display("register rows done");
    // loop 0 at 00.05 s, loops 3 and 4 at 02.01 s, loops 1 and 2 left unset
    bus(1'b1, CTRL_ADDR, 16'h0040);
    bus(1'b1, ROC_ADDR, 16'h0003);
    pv_delta <= 16'h0005;
    bus(1'b1, 12'(PERIOD_BASE + LOOP_STRIDE * 3), 16'h0201);
    bus(1'b1, 12'(PERIOD_BASE + LOOP_STRIDE * 4), 16'h0201);
    bus(1'b1, PERIOD_BASE, 16'h0005);
    repeat (205 * TICK) @(posedge hclk);
    `CHK("fast loop count", 1'b1, cnt[0] >= 39 && cnt[0] <= 41)
    `CHK("unset loops", 0, cnt[1] + cnt[2] + cnt[5])
    `CHK("slow loops once", 2, cnt[3] + cnt[4])
    `CHK("slow in order", 1'b1, tcal[4] - tcal[3] >= TICK)
    bus(1'b0, CALC_CNT_ADDR, 16'h0);
    `CHK("calc count", 16'(total()), rd[15:0])
    bus(1'b0, IRQ_STAT_ADDR, 16'h0);
    `CHK("rate alarm status", 16'h0005, rd[15:0])
    bus(1'b1, IRQ_MASK_ADDR, 16'h0004);
    repeat (3) @(posedge hclk);
    `CHK("rate alarm irq", 1'b1, irq)
    pv_delta <= 16'h0000;
    repeat (12 * TICK) @(posedge hclk);
    bus(1'b1, IRQ_STAT_ADDR, 16'h0007);
    repeat (3) @(posedge hclk);
    `CHK("rate alarm gone", 1'b0, irq)
    $display("scheduling test done");
    // with ladder scans selected, nothing runs until a ladder task ends
    bus(1'b1, CTRL_ADDR, 16'h0041);
    repeat (100) @(posedge hclk);
    s0 = total();
    repeat (20 * TICK) @(posedge hclk);
    `CHK("no ladder no calc", s0, total())
    repeat (10) begin
      ladder_done <= 1'b1;
      @(posedge hclk);
      ladder_done <= 1'b0;
      repeat (TICK) @(posedge hclk);
    end
    `CHK("calc after ladder", 1'b1, total() > s0)
    $display("ladder test done");
    hresetn <= 1'b0;
    repeat (3) @(posedge hclk);
    `CHK("irq in reset", 1'b0, irq)
    `CHK("calc in reset", 1'b0, calc.valid)
    hresetn <= 1'b1;
    bus(1'b0, PERIOD_BASE, 16'h0);
    `CHK("period reset", PERIOD_RST, rd[15:0])
    bus(1'b0, RS_ADDR_ADDR, 16'h0);
    `CHK("table start reset", USER_LOW, rd[15:0])
    bus(1'b0, CTRL_ADDR, 16'h0);
    `CHK("control reset", 16'h0070, rd[15:0])
    $display("reset test done");
    tally_and_finish();
  end
endmodule : tb_pls_scheduler
`default_nettype wire
